// >>> shared/isp_pkg.sv
`default_nettype none
package isp_pkg;
    // Frame layout
    localparam int ISP_FRAME_BITS = 16;
    localparam int ISP_RW_BIT = 15;
    localparam int ISP_ADDR_MSB = 14;
    localparam int ISP_ADDR_LSB = 8;
    localparam int ISP_DATA_MSB = 7;
    localparam logic [3:0] ISP_LAST_BIT = 4'hF;
    localparam logic [15:0] ISP_BURST_CMD = 16'h3E00;

    // Register map
    localparam logic [6:0] ISP_ADDR_STEP = 7'h02;
    localparam logic [6:0] ISP_OUT_FIRST_ADDR = 7'h04;
    localparam logic [6:0] ISP_OUT_LAST_ADDR = 7'h10;
    localparam logic [6:0] ISP_RW_FIRST_ADDR = 7'h1A;
    localparam logic [6:0] ISP_RW_LAST_ADDR = 7'h3F;
    localparam logic [6:0] ISP_ID_ADDR = 7'h56;
    localparam int ISP_WORDS = 64;
    localparam logic [15:0] ISP_RESET_WORD = 16'h0000;
    localparam logic [15:0] ISP_AXIS_STEP = 16'h1111;

    // Timing
    localparam int ISP_CORE_PERIOD_NS = 10;
    localparam longint ISP_SAMPLE_RATE_MILLI_SPS = 819200;
    localparam int ISP_SAMPLE_CYCLES =
        int'(64'd1000000000000 / (ISP_SAMPLE_RATE_MILLI_SPS * ISP_CORE_PERIOD_NS));
    localparam int ISP_DONE_PULSE_NS = 1000;
    localparam int ISP_DONE_PULSE_CYCLES = ISP_DONE_PULSE_NS / ISP_CORE_PERIOD_NS;
    localparam int ISP_SCLK_NORM_KHZ = 2000;
    localparam int ISP_SCLK_BURST_KHZ = 1000;
    localparam int ISP_HALF_NORM_CYCLES =
        (1000000 + 2 * ISP_SCLK_NORM_KHZ * ISP_CORE_PERIOD_NS - 1)
        / (2 * ISP_SCLK_NORM_KHZ * ISP_CORE_PERIOD_NS);
    localparam int ISP_HALF_BURST_CYCLES =
        (1000000 + 2 * ISP_SCLK_BURST_KHZ * ISP_CORE_PERIOD_NS - 1)
        / (2 * ISP_SCLK_BURST_KHZ * ISP_CORE_PERIOD_NS);
    localparam int ISP_STALL_NS = 9000;
    localparam int ISP_STALL_CYCLES =
        (ISP_STALL_NS + ISP_CORE_PERIOD_NS - 1) / ISP_CORE_PERIOD_NS;

    // Host register port
    localparam logic [3:0] ISP_HREG_CTRL = 4'h0;
    localparam logic [3:0] ISP_HREG_TX = 4'h1;
    localparam logic [3:0] ISP_HREG_RX = 4'h2;
    localparam logic [3:0] ISP_HREG_STATUS = 4'h3;
    localparam int ISP_CTRL_BURST_BIT = 0;
    localparam int ISP_STAT_DONE_BIT = 1;
    localparam int ISP_STAT_BUSY_BIT = 0;

    typedef enum logic [4:0] {
        ISP_H_IDLE = 5'b00001,
        ISP_H_LEAD = 5'b00010,
        ISP_H_LOW = 5'b00100,
        ISP_H_HIGH = 5'b01000,
        ISP_H_STALL = 5'b10000
    } isp_host_state_e;

    function automatic logic [5:0] isp_word_idx(input logic [6:0] addr);
        return addr[6:1];
    endfunction
endpackage
`default_nettype wire

// >>> shared/isp_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface isp_link_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic sample_done_line;

    modport dev (
        input sclk,
        input cs_n,
        input mosi,
        output miso,
        output sample_done_line
    );
    modport host (
        output sclk,
        output cs_n,
        output mosi,
        input miso,
        input sample_done_line
    );
endinterface
`default_nettype wire

// >>> verilog/isp_sensor_port.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Registers are 16-bit words, two byte addresses
// - Port answers only while chip select low
// - Sample input bit on each rising clock edge
// - Change output bit on each falling edge
// - Frame returns register read in previous frame
// - Master ignores output after a write frame
// - Self-start, sample outputs at 819.2 SPS
// - Pulse sample-done line after each sample
// - Full duplex: answer while taking next request
// - Master uses mode 3, MSB first
// - Clock at most 2 MHz, burst 1 MHz
// - Single read takes two 16-bit frames
// - Low byte ignored in read frames
// - Read request: address in upper byte
// - Command 0x3E00 streams all output registers
// - Burst tolerates one-clock stall between frames
// - Upper byte at lower-byte address plus one
// - Normal frames spaced at least 9 us
module isp_sensor_port
    import isp_pkg::*;
#(
    parameter int SAMPLE_CYCLES = ISP_SAMPLE_CYCLES,
    parameter logic [15:0] PROD_CODE = 16'h5A01 // Arbitrary value
) (
    input wire logic core_clk,
    input wire logic rst_n,
    isp_link_if.dev lnk
);
    // ---------------- Link domain ----------------
    logic frame_rst_n;
    logic [3:0] bit_cnt_reg;
    logic [15:0] rx_shift_reg;
    logic [15:0] rx_word_reg;
    logic frame_tgl_reg;
    logic [15:0] tx_hold_reg;
    logic miso_reg;
    logic [15:0] tx_word_reg;

    // Bit counter only runs inside a frame
    assign frame_rst_n = rst_n & ~lnk.cs_n;

    always_ff @(posedge lnk.sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            bit_cnt_reg <= 4'h0;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge lnk.sclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_shift_reg <= 16'h0000;
            rx_word_reg <= 16'h0000;
            frame_tgl_reg <= 1'b0;
        end else if (!lnk.cs_n) begin
            rx_shift_reg <= {rx_shift_reg[14:0], lnk.mosi};
            if (bit_cnt_reg == ISP_LAST_BIT) begin
                // Word stays put for a whole frame, so the core reads it safely
                rx_word_reg <= {rx_shift_reg[14:0], lnk.mosi};
                frame_tgl_reg <= ~frame_tgl_reg;
            end
        end
    end

    // tx_word_reg is only updated by the core well before the next frame starts
    always_ff @(negedge lnk.sclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_hold_reg <= 16'h0000;
            miso_reg <= 1'b0;
        end else if (!lnk.cs_n) begin
            if (bit_cnt_reg == 4'h0) begin
                tx_hold_reg <= tx_word_reg;
                miso_reg <= tx_word_reg[ISP_FRAME_BITS - 1];
            end else begin
                miso_reg <= tx_hold_reg[ISP_LAST_BIT - bit_cnt_reg];
            end
        end
    end

    assign lnk.miso = miso_reg;

    // ---------------- Core domain ----------------
    logic [2:0] tgl_sync_reg;
    logic tgl_seen_reg;
    logic frame_evt;
    logic [15:0] mem_reg [0:ISP_WORDS-1];
    logic burst_reg;
    logic [6:0] burst_addr_reg;
    logic [31:0] smpl_cnt_reg;
    logic [15:0] smpl_val_reg;
    logic smpl_tick;
    logic [15:0] done_cnt_reg;
    logic done_reg;
    logic rw;
    logic [6:0] addr;
    logic [7:0] wbyte;
    logic [6:0] burst_next;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tgl_sync_reg <= 3'h0;
            tgl_seen_reg <= 1'b0;
        end else begin
            tgl_sync_reg <= {tgl_sync_reg[1:0], frame_tgl_reg};
            if (frame_evt) begin
                tgl_seen_reg <= tgl_sync_reg[2];
            end
        end
    end

    assign frame_evt = (tgl_sync_reg[1] == tgl_sync_reg[2])
        && (tgl_sync_reg[2] != tgl_seen_reg);
    assign rw = rx_word_reg[ISP_RW_BIT];
    assign addr = rx_word_reg[ISP_ADDR_MSB:ISP_ADDR_LSB];
    assign wbyte = rx_word_reg[ISP_DATA_MSB:0];
    assign burst_next = burst_addr_reg + ISP_ADDR_STEP;

    // Free-running sample timer, no set-up command needed
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            smpl_cnt_reg <= 32'h0;
            smpl_val_reg <= 16'h0000;
        end else if (smpl_tick) begin
            smpl_cnt_reg <= 32'h0;
            smpl_val_reg <= smpl_val_reg + 16'h0001;
        end else begin
            smpl_cnt_reg <= smpl_cnt_reg + 32'h1;
        end
    end

    assign smpl_tick = smpl_cnt_reg == 32'(SAMPLE_CYCLES - 1);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            done_cnt_reg <= 16'h0000;
            done_reg <= 1'b0;
        end else if (smpl_tick) begin
            done_cnt_reg <= 16'(ISP_DONE_PULSE_CYCLES - 1);
            done_reg <= 1'b1;
        end else if (done_cnt_reg != 16'h0000) begin
            done_cnt_reg <= done_cnt_reg - 16'h0001;
        end else begin
            done_reg <= 1'b0;
        end
    end

    assign lnk.sample_done_line = done_reg;

    // Register file: sample loads and write frames
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < ISP_WORDS; i++) begin
                mem_reg[i] <= ISP_RESET_WORD;
            end
            mem_reg[isp_word_idx(ISP_ID_ADDR)] <= PROD_CODE;
        end else begin
            if (smpl_tick) begin
                for (int i = 0; i < 7; i++) begin
                    mem_reg[isp_word_idx(ISP_OUT_FIRST_ADDR) + 6'(i)] <=
                        smpl_val_reg + 16'(ISP_AXIS_STEP * 16'(i));
                end
            end
            if (frame_evt && !burst_reg && rw
                    && addr >= ISP_RW_FIRST_ADDR && addr <= ISP_RW_LAST_ADDR) begin
                if (addr[0]) begin
                    mem_reg[isp_word_idx(addr)][15:8] <= wbyte;
                end else begin
                    mem_reg[isp_word_idx(addr)][7:0] <= wbyte;
                end
            end
        end
    end

    // Answer for the next frame
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_word_reg <= 16'h0000;
            burst_reg <= 1'b0;
            burst_addr_reg <= ISP_OUT_FIRST_ADDR;
        end else if (frame_evt) begin
            if (burst_reg) begin
                // Incoming words are ignored until the burst ends
                if (burst_next > ISP_OUT_LAST_ADDR) begin
                    burst_reg <= 1'b0;
                    tx_word_reg <= 16'h0000;
                end else begin
                    burst_addr_reg <= burst_next;
                    tx_word_reg <= mem_reg[isp_word_idx(burst_next)];
                end
            end else if (rx_word_reg == ISP_BURST_CMD) begin
                burst_reg <= 1'b1;
                burst_addr_reg <= ISP_OUT_FIRST_ADDR;
                tx_word_reg <= mem_reg[isp_word_idx(ISP_OUT_FIRST_ADDR)];
            end else if (!rw) begin
                // Whole word whichever byte address, low byte unused
                tx_word_reg <= mem_reg[isp_word_idx(addr)];
            end else begin
                tx_word_reg <= 16'h0000;
            end
        end
    end
endmodule
`default_nettype wire

// >>> verilog/isp_host_master.sv
`timescale 1ns/1ps
`default_nettype none
module isp_host_master
    import isp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    isp_link_if.host lnk
);
    isp_host_state_e state_reg;
    logic [9:0] cnt_reg;
    logic [4:0] bits_reg;
    logic [15:0] tx_shift_reg;
    logic [15:0] rx_shift_reg;
    logic [15:0] rx_word_reg;
    logic burst_mode_reg;
    logic sclk_reg;
    logic cs_n_reg;
    logic mosi_reg;
    logic [2:0] miso_sync_reg;
    logic miso_reg;
    logic [2:0] done_sync_reg;
    logic done_lvl_reg;
    logic done_flag_reg;
    logic [9:0] half;
    logic [9:0] stall;
    logic done_rise;

    assign half = burst_mode_reg ? 10'(ISP_HALF_BURST_CYCLES - 1)
        : 10'(ISP_HALF_NORM_CYCLES - 1);
    assign stall = burst_mode_reg ? 10'(2 * ISP_HALF_BURST_CYCLES - 1)
        : 10'(ISP_STALL_CYCLES - 1);

    // Pin inputs: three stages, accepted when the last two agree
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            miso_sync_reg <= 3'h0;
            miso_reg <= 1'b0;
            done_sync_reg <= 3'h0;
            done_lvl_reg <= 1'b0;
        end else begin
            miso_sync_reg <= {miso_sync_reg[1:0], lnk.miso};
            done_sync_reg <= {done_sync_reg[1:0], lnk.sample_done_line};
            if (miso_sync_reg[1] == miso_sync_reg[2]) begin
                miso_reg <= miso_sync_reg[2];
            end
            if (done_sync_reg[1] == done_sync_reg[2]) begin
                done_lvl_reg <= done_sync_reg[2];
            end
        end
    end

    assign done_rise = (done_sync_reg[1] == done_sync_reg[2])
        && done_sync_reg[2] && !done_lvl_reg;

    // Sticky sample-done flag, set wins over write-one-to-clear
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            done_flag_reg <= 1'b0;
        end else if (done_rise) begin
            done_flag_reg <= 1'b1;
        end else if (reg_wr && reg_addr == ISP_HREG_STATUS
                && reg_wdata[ISP_STAT_DONE_BIT]) begin
            done_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            burst_mode_reg <= 1'b0;
        end else if (reg_wr && reg_addr == ISP_HREG_CTRL) begin
            burst_mode_reg <= reg_wdata[ISP_CTRL_BURST_BIT];
        end
    end

    // Frame engine: mode 3, clock idles high, MSB first
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ISP_H_IDLE;
            cnt_reg <= 10'h000;
            bits_reg <= 5'h00;
            tx_shift_reg <= 16'h0000;
            rx_shift_reg <= 16'h0000;
            rx_word_reg <= 16'h0000;
            sclk_reg <= 1'b1;
            cs_n_reg <= 1'b1;
            mosi_reg <= 1'b0;
        end else begin
            case (state_reg)
                ISP_H_IDLE: begin
                    if (reg_wr && reg_addr == ISP_HREG_TX) begin
                        tx_shift_reg <= reg_wdata;
                        cs_n_reg <= 1'b0;
                        bits_reg <= 5'h00;
                        cnt_reg <= half;
                        state_reg <= ISP_H_LEAD;
                    end
                end
                ISP_H_LEAD, ISP_H_HIGH: begin
                    if (cnt_reg != 10'h000) begin
                        cnt_reg <= cnt_reg - 10'h001;
                    end else if (bits_reg == 5'(ISP_FRAME_BITS)) begin
                        cs_n_reg <= 1'b1;
                        rx_word_reg <= rx_shift_reg;
                        cnt_reg <= stall;
                        state_reg <= ISP_H_STALL;
                    end else begin
                        sclk_reg <= 1'b0;
                        mosi_reg <= tx_shift_reg[ISP_FRAME_BITS - 1];
                        tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};
                        cnt_reg <= half;
                        state_reg <= ISP_H_LOW;
                    end
                end
                ISP_H_LOW: begin
                    if (cnt_reg != 10'h000) begin
                        cnt_reg <= cnt_reg - 10'h001;
                    end else begin
                        sclk_reg <= 1'b1;
                        rx_shift_reg <= {rx_shift_reg[14:0], miso_reg};
                        bits_reg <= bits_reg + 5'h01;
                        cnt_reg <= half;
                        state_reg <= ISP_H_HIGH;
                    end
                end
                ISP_H_STALL: begin
                    if (cnt_reg != 10'h000) begin
                        cnt_reg <= cnt_reg - 10'h001;
                    end else begin
                        state_reg <= ISP_H_IDLE;
                    end
                end
                default: begin
                    state_reg <= ISP_H_IDLE;
                    sclk_reg <= 1'b1;
                    cs_n_reg <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                ISP_HREG_CTRL: reg_rdata <= {15'h0000, burst_mode_reg};
                ISP_HREG_RX: reg_rdata <= rx_word_reg;
                ISP_HREG_STATUS: reg_rdata <= {14'h0000, done_flag_reg,
                    state_reg != ISP_H_IDLE};
                default: reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    assign lnk.sclk = sclk_reg;
    assign lnk.cs_n = cs_n_reg;
    assign lnk.mosi = mosi_reg;
endmodule
`default_nettype wire

// >>> verif/isp_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
module isp_link_sva
    import isp_pkg::*;
#(
    parameter int SAMPLE_CYCLES = ISP_SAMPLE_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic sample_done_line
);
    logic done_q;
    logic sclk_q;
    logic seen;
    logic [31:0] gap;
    logic [7:0] hi_cnt;
    logic [7:0] low_cnt;
    logic [4:0] rise_cnt;
    logic [15:0] idle_cnt;
    logic norm_q;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // Cycles since the previous done pulse began
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            done_q <= 1'b0;
            seen <= 1'b0;
            gap <= 32'h0;
        end else begin
            done_q <= sample_done_line;
            if (sample_done_line && !done_q) begin
                seen <= 1'b1;
                gap <= 32'h1;
            end else begin
                gap <= gap + 32'h1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hi_cnt <= 8'h0;
        end else begin
            hi_cnt <= sample_done_line ? hi_cnt + 8'h1 : 8'h0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt <= 8'h0;
        end else begin
            low_cnt <= sclk ? 8'h0 : low_cnt + 8'h1;
        end
    end

    // Serial clock rises inside the current frame
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_q <= 1'b1;
            rise_cnt <= 5'h0;
        end else begin
            sclk_q <= sclk;
            if (cs_n) begin
                rise_cnt <= 5'h0;
            end else if (sclk && !sclk_q) begin
                rise_cnt <= rise_cnt + 5'h1;
            end
        end
    end

    // Whether the frame just ended ran at the normal clock rate
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            norm_q <= 1'b0;
        end else if (sclk && !sclk_q && !cs_n) begin
            norm_q <= low_cnt == ISP_HALF_NORM_CYCLES;
        end
    end

    // Starts saturated so the first frame after reset is not flagged
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_cnt <= 16'hFFFF;
        end else if (!cs_n) begin
            idle_cnt <= 16'h0;
        end else if (idle_cnt != 16'hFFFF) begin
            idle_cnt <= idle_cnt + 16'h1;
        end
    end

    AST_CS_LEAD: assert property ($fell(cs_n) |-> sclk [*8])
        else $error("serial clock moved too soon after chip select");
    AST_IDLE_HIGH: assert property (cs_n |-> sclk)
        else $error("serial clock not high while deselected");
    AST_MOSI_HOLD: assert property (!cs_n && !$past(cs_n) && sclk && $past(sclk)
        |-> $stable(mosi))
        else $error("mosi changed while clock high");
    AST_MISO_HOLD: assert property (!cs_n && !$past(cs_n) && sclk && $past(sclk)
        |-> $stable(miso))
        else $error("miso changed while clock high");
    AST_FRAME_BITS: assert property ($rose(cs_n) |-> rise_cnt == 5'd16)
        else $error("frame did not carry sixteen bits");
    AST_HALF_LOW: assert property ($rose(sclk) && !cs_n
        |-> low_cnt == ISP_HALF_NORM_CYCLES || low_cnt == ISP_HALF_BURST_CYCLES)
        else $error("serial clock low half has wrong length");
    AST_STALL: assert property ($fell(cs_n) |-> idle_cnt >= 16'd100)
        else $error("stall between frames too short");
    AST_NORM_STALL: assert property ($fell(cs_n) && norm_q
        |-> idle_cnt >= 16'(ISP_STALL_CYCLES))
        else $error("stall after a normal frame too short");
    AST_DONE_WIDTH: assert property ($fell(sample_done_line)
        |-> hi_cnt == ISP_DONE_PULSE_CYCLES)
        else $error("done pulse has wrong width");
    AST_DONE_PERIOD: assert property (seen && sample_done_line && !done_q
        |-> gap == SAMPLE_CYCLES)
        else $error("done pulses not one sample period apart");

    COV_FRAME: cover property ($rose(cs_n));
    COV_BURST_CLK: cover property ($rose(sclk) && low_cnt == ISP_HALF_BURST_CYCLES);
    COV_DONE: cover property ($fell(sample_done_line));
endmodule
`default_nettype wire

// >>> verif/imu_spi_register_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module imu_spi_register_port_tb
    import isp_pkg::*;
;
    localparam int SAMPLE_CYC = 20000;
    localparam logic [15:0] PROD = 16'h7C21; // Arbitrary value

    logic core_clk = 1'b0;
    logic rst_n = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [15:0] mon_mosi = 16'h0000;
    int bad_count = 0;
    int n_compared = 0;

    isp_link_if lnk ();

    isp_sensor_port #(.SAMPLE_CYCLES(SAMPLE_CYC), .PROD_CODE(PROD)) i_isp_sensor_port (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .lnk(lnk)
    );

    isp_host_master i_isp_host_master (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .lnk(lnk)
    );

    isp_link_sva #(.SAMPLE_CYCLES(SAMPLE_CYC)) i_isp_link_sva (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .sclk(lnk.sclk),
        .cs_n(lnk.cs_n),
        .mosi(lnk.mosi),
        .miso(lnk.miso),
        .sample_done_line(lnk.sample_done_line)
    );

    always #5 core_clk = ~core_clk;

    // Word seen on the wire, shifted in at each serial clock rise
    always @(posedge lnk.sclk) begin
        if (!lnk.cs_n) begin
            mon_mosi <= {mon_mosi[14:0], lnk.mosi};
        end
    end

    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // One whole frame: send a word, wait for the stall to end, fetch the answer
    task automatic frame(input logic [15:0] w, output logic [15:0] rx);
        logic [15:0] st;
        int i;
        reg_write(ISP_HREG_TX, w);
        st = 16'h0001;
        for (i = 0; i < 4000 && st[ISP_STAT_BUSY_BIT] !== 1'b0; i++) begin
            reg_read(ISP_HREG_STATUS, st);
        end
        chk("busy", 16'h0000, 16'(st[ISP_STAT_BUSY_BIT]));
        chk("mosi word", w, mon_mosi);
        reg_read(ISP_HREG_RX, rx);
    endtask

    task automatic wait_done_rise;
        int i;
        for (i = 0; i < 25000; i++) begin
            @(posedge core_clk);
            #1;
            if (lnk.sample_done_line === 1'b1) begin
                break;
            end
        end
        chk("done pulse", 16'h0001, 16'(lnk.sample_done_line));
    endtask

    task automatic test_reset;
        logic [15:0] d;
        chk("idle chip select", 16'h0001, 16'(lnk.cs_n));
        chk("idle clock", 16'h0001, 16'(lnk.sclk));
        reg_read(ISP_HREG_STATUS, d);
        chk("status", 16'h0000, d);
        reg_read(4'hA, d);
        chk("unmapped", 16'h0000, d);
    endtask

    // Byte writes, reads at both byte addresses, refused write, after-write answers
    task automatic test_frames;
        logic [15:0] tx[8] = '{16'h9A5A, 16'h9BC3, 16'h1BFF, 16'h5600,
                               16'hC011, 16'h4000, 16'h1A00, 16'h0000};
        logic [15:0] exp[8] = '{16'h0000, 16'h0000, 16'h0000, 16'hC35A,
                                PROD, 16'h0000, 16'h0000, 16'hC35A};
        logic [15:0] rx;
        int i;
        for (i = 0; i < 8; i++) begin
            frame(tx[i], rx);
            if (i > 0) begin
                chk("frame answer", exp[i], rx);
            end
        end
    endtask

    task automatic test_burst;
        logic [15:0] w[7];
        logic [15:0] rx;
        int i;
        reg_write(ISP_HREG_CTRL, 16'h0001);
        wait_done_rise();
        frame(ISP_BURST_CMD, rx);
        for (i = 0; i < 7; i++) begin
            frame(16'h0000, w[i]);
        end
        for (i = 1; i < 7; i++) begin
            chk("burst word", w[0] + 16'(i) * ISP_AXIS_STEP, w[i]);
        end
        frame(16'h0000, rx);
        chk("after burst", 16'h0000, rx);
        reg_write(ISP_HREG_CTRL, 16'h0000);
    endtask

    task automatic test_done_flag;
        logic [15:0] st;
        reg_write(ISP_HREG_STATUS, 16'h0002);
        reg_read(ISP_HREG_STATUS, st);
        chk("done flag idle", 16'h0000, st & 16'h0002);
        wait_done_rise();
        repeat (10) @(posedge core_clk);
        reg_read(ISP_HREG_STATUS, st);
        chk("done flag set", 16'h0002, st & 16'h0002);
        reg_write(ISP_HREG_STATUS, 16'h0002);
        reg_read(ISP_HREG_STATUS, st);
        chk("done flag clear", 16'h0000, st & 16'h0002);
        repeat (120) @(posedge core_clk);
    endtask

    initial begin
        rst_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        test_reset();
        test_frames();
        test_burst();
        test_done_flag();
        give_verdict();
    end

    initial begin
        #800000;
        bad_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
